// ### sfsm_consts.vh
// What this block does
// - Fail-safe: regulators off, transceivers wake-capable
// - Limp-home output active during fail-safe
// - Outside development mode: watchdog failure enters fail-safe or restart
// - Rail undervoltage timeout while vs_above_lhuv, or thermal shutdown: fail-safe
// - Config 2 only: clamped reset enters fail-safe
// - Overtemperature fail-safe latched until cooled, then restart
// - Wake in non-thermal fail-safe: restart, record, clear counter
// - First serial word in normal reports cause
// - Test pin low at power-up: development mode
// - Development mode: watchdog failure no reset, rail on
// - Development mode: watchdog failure sets reset indication
// - Development mode: watchdog never reaches fail-safe/restart
// - Config 2: watchdog failure goes directly fail-safe
// - Otherwise second consecutive watchdog failure: fail-safe
// - Rail fed externally without battery: factory flash
`ifndef SFSM_CONSTS_VH
`define SFSM_CONSTS_VH
`define SFSM_ST_INIT 3'h0
`define SFSM_ST_NORMAL 3'h1
`define SFSM_ST_RESTART 3'h2
`define SFSM_ST_FAILSAFE 3'h3
`define SFSM_ST_FLASH 3'h4
`define SFSM_CAUSE_NONE 3'h0
`define SFSM_CAUSE_WDOG 3'h1
`define SFSM_CAUSE_UVTO 3'h2
`define SFSM_CAUSE_THERM 3'h3
`define SFSM_CAUSE_CLAMP 3'h4
`define SFSM_CFG_DEV 2'h0
`define SFSM_CFG_2 2'h2
`define SFSM_RESTART_CYC 8'h10
`endif

// ### sfsm_mcu.sv
`default_nettype none
module sfsm_mcu (
  input wire logic mclk,
  input wire logic rd,
  input wire logic [2:0] fs_cause_q,
  output var logic spi_word_done = 1'b0,
  output var logic [2:0] got
);
  timeunit 1ns;
  timeprecision 100ps;
  // One word per request; keeps its cause field
  always @(posedge mclk) begin
    spi_word_done <= rd;
    if (rd)
      got <= fs_cause_q;
  end
endmodule
`default_nettype wire

// ### sfsm_mode_ctrl.v
`include "sfsm_consts.vh"
`default_nettype none
module sfsm_mode_ctrl (
  input wire mclk,
  input wire rst,
  input wire test_pin_low,
  input wire [1:0] cfg_sel,
  input wire wdog_fail,
  input wire uv_timeout,
  input wire vs_above_lhuv,
  input wire therm_shutdown,
  input wire therm_below_hyst,
  input wire reset_clamped,
  input wire wake_event,
  input wire [3:0] wake_src,
  input wire rail_ext_powered,
  input wire vs_present,
  input wire spi_word_done,
  output reg [2:0] mode_q,
  output reg regs_on_q,
  output reg xcvr_wake_cap_q,
  output reg limp_home_q,
  output reg reset_out_q,
  output reg dev_mode_q,
  output reg reset_ind_q,
  output reg int_q,
  output reg [2:0] fs_cause_q,
  output reg [3:0] wake_rec_q,
  output reg cause_valid_q,
  output reg [1:0] wd_fail_cnt_q
);
  reg [2:0] mode_d;
  reg [2:0] cause_d;
  reg [1:0] cnt_d;
  reg [7:0] rs_cnt_q;
  reg por_done_q;
  reg wd_fs;
  reg wd_rs;
  reg go_fs;

  // Configuration (cfg_sel 2 only) that skips restart on watchdog failure and reset clamp
  function is_cfg24;
    input [1:0] sel;
    begin
      is_cfg24 = (sel == `SFSM_CFG_2);
    end
  endfunction

  // Rail fed from outside while the battery is absent
  function is_flash;
    input ext;
    input vs;
    begin
      is_flash = ext & ~vs;
    end
  endfunction

  wire cfg24 = is_cfg24(cfg_sel);
  wire flash = is_flash(rail_ext_powered, vs_present);
  wire dev = dev_mode_q;

  // Watchdog failure reaction by configuration
  always @* begin
    wd_fs = 1'b0;
    wd_rs = 1'b0;
    if (wdog_fail && !dev) begin
      if (cfg_sel == `SFSM_CFG_2) begin
        wd_fs = 1'b1;
      end else if (cfg24) begin
        wd_fs = 1'b1;
      end else begin
        wd_fs = (wd_fail_cnt_q != 2'h0);
        wd_rs = ~wd_fs;
      end
    end
  end

  // Fail-safe triggers in priority order
  always @* begin
    go_fs = 1'b0;
    cause_d = `SFSM_CAUSE_NONE;
    if (therm_shutdown) begin
      go_fs = 1'b1;
      cause_d = `SFSM_CAUSE_THERM;
    end else if (uv_timeout && vs_above_lhuv) begin
      go_fs = 1'b1;
      cause_d = `SFSM_CAUSE_UVTO;
    end else if (reset_clamped && cfg24) begin
      go_fs = 1'b1;
      cause_d = `SFSM_CAUSE_CLAMP;
    end else if (wd_fs) begin
      go_fs = 1'b1;
      cause_d = `SFSM_CAUSE_WDOG;
    end
  end

  // Next mode and watchdog failure counter
  always @* begin
    mode_d = mode_q;
    cnt_d = wd_fail_cnt_q;
    if (wdog_fail && !dev && wd_fail_cnt_q != 2'h3) begin
      cnt_d = wd_fail_cnt_q + 2'h1;
    end
    case (mode_q)
      `SFSM_ST_FAILSAFE: begin
        if (fs_cause_q == `SFSM_CAUSE_THERM) begin
          if (therm_below_hyst) begin
            mode_d = `SFSM_ST_RESTART;
          end
        end else if (wake_event) begin
          mode_d = `SFSM_ST_RESTART;
          cnt_d = 2'h0;
        end
      end
      `SFSM_ST_FLASH: begin
        if (!flash) begin
          mode_d = `SFSM_ST_RESTART;
        end
      end
      `SFSM_ST_RESTART: begin
        if (go_fs) begin
          mode_d = `SFSM_ST_FAILSAFE;
        end else if (rs_cnt_q == 8'h00) begin
          mode_d = `SFSM_ST_NORMAL;
        end
      end
      `SFSM_ST_INIT, `SFSM_ST_NORMAL: begin
        if (go_fs) begin
          mode_d = `SFSM_ST_FAILSAFE;
        end else if (wd_rs) begin
          mode_d = `SFSM_ST_RESTART;
        end else if (mode_q == `SFSM_ST_INIT && por_done_q) begin
          mode_d = `SFSM_ST_NORMAL;
        end
      end
      default: begin
        mode_d = `SFSM_ST_INIT;
      end
    endcase
    if (flash) begin
      mode_d = `SFSM_ST_FLASH;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      mode_q <= `SFSM_ST_INIT;
      wd_fail_cnt_q <= 2'h0;
      por_done_q <= 1'b0;
      dev_mode_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
      // Strap taken once, in the first cycle after reset
      if (!por_done_q) begin
        dev_mode_q <= test_pin_low;
      end
      mode_q <= mode_d;
      wd_fail_cnt_q <= cnt_d;
    end
  end

  // Pins follow the next mode so they change together with mode_q
  always @(posedge mclk) begin
    if (rst) begin
      regs_on_q <= 1'b1;
      xcvr_wake_cap_q <= 1'b0;
      limp_home_q <= 1'b0;
      reset_out_q <= 1'b1;
    end else begin
      regs_on_q <= (mode_d != `SFSM_ST_FAILSAFE) && (mode_d != `SFSM_ST_FLASH);
      xcvr_wake_cap_q <= (mode_d == `SFSM_ST_FAILSAFE) || (mode_d == `SFSM_ST_FLASH);
      limp_home_q <= (mode_d == `SFSM_ST_FAILSAFE);
      // Reset held outside normal; dev mode keeps watchdog away from it
      reset_out_q <= (mode_d != `SFSM_ST_NORMAL);
    end
  end

  // Restart dwell, reloaded on each entry into restart
  always @(posedge mclk) begin
    if (rst) begin
      rs_cnt_q <= `SFSM_RESTART_CYC;
    end else if (mode_d == `SFSM_ST_RESTART && mode_q != `SFSM_ST_RESTART) begin
      rs_cnt_q <= `SFSM_RESTART_CYC;
    end else if (rs_cnt_q != 8'h00) begin
      rs_cnt_q <= rs_cnt_q - 8'h01;
    end
  end

  // Watchdog indication in dev mode; a new failure beats the readout clear
  always @(posedge mclk) begin
    if (rst) begin
      reset_ind_q <= 1'b0;
      int_q <= 1'b0;
    end else if (wdog_fail && dev) begin
      reset_ind_q <= 1'b1;
      int_q <= 1'b1;
    end else if (spi_word_done) begin
      reset_ind_q <= 1'b0;
      int_q <= 1'b0;
    end
  end

  // Cause and wake record survive until the first word read in normal
  always @(posedge mclk) begin
    if (rst) begin
      fs_cause_q <= `SFSM_CAUSE_NONE;
      wake_rec_q <= 4'h0;
      cause_valid_q <= 1'b0;
    end else if (mode_q != `SFSM_ST_FAILSAFE && mode_d == `SFSM_ST_FAILSAFE) begin
      fs_cause_q <= cause_d;
      cause_valid_q <= 1'b1;
      wake_rec_q <= 4'h0;
    end else if (mode_q == `SFSM_ST_FAILSAFE && wake_event &&
                 fs_cause_q != `SFSM_CAUSE_THERM) begin
      wake_rec_q <= wake_src;
    end else if (mode_q == `SFSM_ST_NORMAL && spi_word_done && cause_valid_q) begin
      cause_valid_q <= 1'b0;
      fs_cause_q <= `SFSM_CAUSE_NONE;
      wake_rec_q <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ### sfsm_sva.sv
`default_nettype none
module sfsm_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wdog_fail,
  input wire logic uv_timeout,
  input wire logic therm_shutdown,
  input wire logic therm_below_hyst,
  input wire logic reset_clamped,
  input wire logic wake_event,
  input wire logic rail_ext_powered,
  input wire logic vs_present,
  input wire logic limp_home_q,
  input wire logic regs_on_q,
  input wire logic dev_mode_q,
  input wire logic [1:0] cfg_sel,
  input wire logic [1:0] wd_fail_cnt_q,
  input wire logic [2:0] mode_q,
  input wire logic [2:0] fs_cause_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // No other fault and no flash supply
  wire fl = rail_ext_powered & ~vs_present;
  wire qt = ~therm_shutdown & ~uv_timeout & ~reset_clamped & ~fl;
  wire nm = mode_q == 3'h1;
  wire fs = mode_q == 3'h3;
  fs_out_a: assert property (fs |-> limp_home_q && !regs_on_q)
    else $error("bad fail-safe outputs");
  cfg2_fs_a: assert property (nm && cfg_sel == 2'h2 && wdog_fail && !dev_mode_q && qt
    |=> fs) else $error("no direct fail-safe");
  therm_fs_a: assert property (nm && therm_shutdown && !fl |=> fs && fs_cause_q == 3'h3)
    else $error("no thermal fail-safe");
  therm_latch_a: assert property (fs && fs_cause_q == 3'h3 && !therm_below_hyst && !fl
    |=> fs) else $error("thermal latch lost");
  wake_exit_a: assert property (fs && fs_cause_q != 3'h3 && wake_event && !fl |=>
    mode_q == 3'h2 && wd_fail_cnt_q == 2'h0) else $error("bad wake exit");
  dev_wdog_a: assert property (dev_mode_q && nm && wdog_fail && qt |=> nm)
    else $error("dev mode left normal");
  wd_second_a: assert property (nm && wdog_fail && wd_fail_cnt_q == 2'h1 && !dev_mode_q
    && qt |=> fs) else $error("no second failure fail-safe");
  flash_mode_a: assert property (fl |=> mode_q == 3'h4) else $error("no flash mode");
  cover property (fs && fs_cause_q != 3'h3 && wake_event);
  cover property (fs && fs_cause_q == 3'h3);
  cover property (dev_mode_q && wdog_fail);
  cover property (mode_q == 3'h4);
endmodule
bind sfsm_mode_ctrl sfsm_sva u_sfsm_sva (.*);
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, test_pin_low, vs_above_lhuv, therm_below_hyst, rail_ext_powered, vs_present;
  logic rd, spi_word_done, regs_on_q, xcvr_wake_cap_q, limp_home_q, reset_out_q, dev_mode_q;
  logic reset_ind_q, int_q, cause_valid_q;
  wire therm_shutdown, reset_clamped, uv_timeout, wdog_fail, wake_event;
  logic [4:0] ev;
  logic [1:0] cfg_sel, wd_fail_cnt_q;
  logic [2:0] mode_q, fs_cause_q, got;
  logic [3:0] wake_src, wake_rec_q;
  int fails, n_checks, cyc;
  assign {therm_shutdown, reset_clamped, uv_timeout, wdog_fail, wake_event} = ev;
  sfsm_mode_ctrl u_sfsm_mode_ctrl (.*);
  sfsm_mcu u_sfsm_mcu (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) final_report(1);
  end
  task final_report(input int extra);
    fails += extra;
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(input logic [3:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %0t: %h not %h", $time, s, e);
    end
  endtask
  // Bits: thermal, clamp, undervoltage, watchdog, wake
  task hit(input logic [4:0] v);
    ev = v;
    step(1);
    ev = 5'h0;
  endtask
  task rs(input logic t);
    rst = 1'b1;
    test_pin_low = t;
    step(12);
    rst = 1'b0;
    step(3);
  endtask
  function logic [3:0] ecause(input int k);
    return k == 4 ? 4'h3 : k == 3 ? 4'h4 : 4'(k);
  endfunction
  initial begin
    {ev, therm_below_hyst, rail_ext_powered, rd, wake_src, cfg_sel} = 14'h0;
    {rst, test_pin_low, vs_above_lhuv, vs_present} = 4'hb;
    void'($urandom(31));
    rs(1'b0);
    for (int k = 1; k < 5; k++) begin
      cfg_sel = k == 1 ? {1'($urandom), 1'b1} : 2'h2;
      if (k == 1) hit(5'h02);
      if (k == 1) chk(mode_q, 4'h2);
      step(20);
      hit(5'h01 << k);
      chk(mode_q, 4'h3);
      chk(fs_cause_q, ecause(k));
      chk({limp_home_q, regs_on_q, xcvr_wake_cap_q}, 4'h5);
      wake_src = 4'($urandom);
      hit(5'h01);
      chk(mode_q, k == 4 ? 4'h3 : 4'h2);
      if (k < 4) chk(wake_rec_q, wake_src);
      therm_below_hyst = 1'b1;
      step(1);
      therm_below_hyst = 1'b0;
      chk(mode_q, 4'h2);
      step(20);
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(2);
      chk(got, ecause(k));
      chk(cause_valid_q, 4'h0);
    end
    rs(1'b1);
    hit(5'h02);
    chk(mode_q, 4'h1);
    chk({dev_mode_q, reset_ind_q, int_q, reset_out_q}, 4'he);
    hit(5'h04);
    chk(mode_q, 4'h3);
    {rail_ext_powered, vs_present} = 2'h2;
    step(2);
    chk(mode_q, 4'h4);
    chk({limp_home_q, regs_on_q, xcvr_wake_cap_q}, 4'h1);
    final_report(0);
  end
endmodule
`default_nettype wire
